// ### logic/rvc_channel.sv
/*
 * Virtual serial channel relaying bytes between the host link and a
 * monitor on the target, reached through four ROM-mapped registers.
 * Assumes ROM strobes arrive asynchronously and the host link byte
 * interface and session control run on mclk_i.
 */
`default_nettype none
module rvc_channel #(
    parameter int unsigned SENSE_CYCLES =
        rvc_pkg::SENSE_PERIOD_MS * rvc_pkg::CLK_KHZ
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // session control
    input wire logic session_start_i,
    input wire rvc_pkg::rvc_cfg_t cfg_i,
    output logic session_active_o,
    // target rom bus pins
    input wire rvc_pkg::rvc_rom_t rom_i,
    output logic [7:0] rom_data_o,
    output logic rom_data_oe_o,
    // target interrupt and reset pins
    output logic int_p_o,
    output logic int_n_o,
    output logic target_rst_o,
    // host link, host to target
    input wire logic host_rx_valid_i,
    input wire logic [7:0] host_rx_data_i,
    output logic rx_lost_o,
    // host link, target to host
    output logic host_tx_valid_o,
    output logic [7:0] host_tx_data_o,
    input wire logic host_tx_ready_i,
    // host requests and control line pin
    input wire logic host_int_req_i,
    input wire logic host_rst_req_i,
    input wire logic host_ctl_line_i
);
    import rvc_pkg::*;

    rvc_state_t q;
    rvc_state_t n;
    logic rd_s;
    logic wr_s;
    logic hit_s;
    logic start_w;
    logic act_w;
    logic push_w;
    logic pop_w;
    logic tog_w;
    logic [5:0] limit_w;
    logic [7:0] head_w;

    // four-byte window aligned on its low two bits
    function automatic logic addr_hit(logic [ADDR_W-1:0] a,
                                      logic [ADDR_W-1:0] b);
        addr_hit = a[ADDR_W-1:2] == b[ADDR_W-1:2];
    endfunction

    function automatic logic [3:0] acc_delay(rvc_cfg_t c, logic is_tx);
        logic [3:0] d;
        d = 4'h0;
        if (c.gen2) begin
            case (c.timing)
                2'h0: d = G2_DLY0_CYC;
                2'h1: d = G2_DLY1_CYC;
                2'h2: d = G2_DLY2_CYC;
                default: d = 4'h0;
            endcase
        end else begin
            case (c.timing)
                2'h0: d = 4'h0;
                2'h1: d = is_tx ? G1_DLY_CYC : 4'h0;
                default: d = G1_DLY_CYC;
            endcase
        end
        acc_delay = d;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // decode of the synchronised bus
    always_comb begin
        rd_s = !q.rom_s2.ce_n && !q.rom_s2.oe_n;
        wr_s = !q.rom_s2.ce_n && !q.rom_s2.we_n;
        hit_s = addr_hit(q.rom_s2.addr, q.cfg.base);
        start_w = q.active && q.acc == ACC_IDLE && (rd_s || wr_s) && hit_s;
        act_w = q.acc == ACC_WAIT && q.dly == 4'h0;
        limit_w = q.cfg.fast ? RX_FAST_DEPTH : RX_DEPTH;
        push_w = q.active && host_rx_valid_i && q.count < limit_w;
        head_w = q.mem[q.rd_ptr];
        pop_w = act_w && rd_s && q.ofs == OFS_RXDATA && q.count != 6'h00;
        tog_w = q.ctl_s2 ^ q.ctl_prev;
    end

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        n = q;
        n.rom_s1 = rom_i;
        n.rom_s2 = q.rom_s1;
        n.ctl_s1 = host_ctl_line_i;
        n.ctl_s2 = q.ctl_s1;
        n.ctl_prev = q.ctl_s2;
        n.lost = q.active && host_rx_valid_i && !push_w;
        if (q.int_cnt != 4'h0) n.int_cnt = q.int_cnt - 4'h1;
        if (q.rst_cnt != 4'h0) n.rst_cnt = q.rst_cnt - 4'h1;
        if (q.active && host_int_req_i) n.int_cnt = PULSE_CYC;
        if (q.active && host_rst_req_i) n.rst_cnt = PULSE_CYC;
        if (q.tx_valid && host_tx_ready_i) n.tx_valid = 1'b0;

        // access sequencer
        case (q.acc)
            ACC_IDLE: begin
                if (start_w) begin
                    n.acc = ACC_WAIT;
                    n.ofs = q.rom_s2.addr[1:0];
                    n.dly = acc_delay(q.cfg,
                        !q.rom_s2.addr[1]);
                end
            end
            ACC_WAIT: begin
                if (q.dly != 4'h0) begin
                    n.dly = q.dly - 4'h1;
                end else begin
                    n.acc = ACC_DONE;
                    n.ofs = q.rom_s2.addr[1:0];
                    n.rd_oe = rd_s;
                    n.rd_data = 8'h00;
                    if (wr_s) begin
                        if (q.cfg.gen2 && q.cfg.direct_wr &&
                            q.rom_s2.addr[1:0] == OFS_BIT0 &&
                            !q.tx_valid) begin
                            n.tx_data = q.rom_s2.wdata;
                            n.tx_valid = 1'b1;
                        end
                    end else if (rd_s) begin
                        case (q.rom_s2.addr[1:0])
                            OFS_BIT0, OFS_BIT1: begin
                                // lsb first, one bit per read
                                n.txsh = {q.rom_s2.addr[0], q.txsh[7:1]};
                                n.txcnt = q.txcnt + 3'h1;
                                if (q.txcnt == 3'h7 && !q.tx_valid) begin
                                    n.tx_data = {q.rom_s2.addr[0],
                                                 q.txsh[7:1]};
                                    n.tx_valid = 1'b1;
                                end
                            end
                            OFS_RXDATA: begin
                                if (q.count != 6'h00) begin
                                    n.rd_data = head_w;
                                    n.rd_ptr = q.rd_ptr == RX_LAST ?
                                        6'h00 : q.rd_ptr + 6'h01;
                                end
                            end
                            default: begin
                                n.rd_data[STAT_HBA_BIT] =
                                    q.count != 6'h00;
                                n.rd_data[STAT_TXBUSY_BIT] = q.tx_valid;
                            end
                        endcase
                    end
                end
            end
            ACC_DONE: begin
                if (!rd_s && !wr_s) begin
                    n.acc = ACC_IDLE;
                    n.rd_oe = 1'b0;
                end else if (q.cfg.burst && hit_s &&
                             q.rom_s2.addr[1:0] != q.ofs) begin
                    n.acc = ACC_WAIT;
                    n.ofs = q.rom_s2.addr[1:0];
                    n.dly = acc_delay(q.cfg, !q.rom_s2.addr[1]);
                end
            end
            default: n.acc = ACC_IDLE;
        endcase

        // receive buffer
        if (push_w) begin
            n.mem[q.wr_ptr] = host_rx_data_i;
            n.wr_ptr = q.wr_ptr == RX_LAST ? 6'h00 : q.wr_ptr + 6'h01;
        end
        n.count = q.count + {5'h00, push_w} - {5'h00, pop_w};

        // session break by control line toggles
        if (q.win_cnt != 32'h0) n.win_cnt = q.win_cnt - 32'h1;
        else n.tog_cnt = 3'h0;
        if (q.active && tog_w) begin
            if (q.tog_cnt == 3'h0 || q.win_cnt == 32'h0) begin
                n.win_cnt = 32'(SENSE_CYCLES - 1);
                n.tog_cnt = 3'h1;
            end else begin
                n.tog_cnt = q.tog_cnt + 3'h1;
            end
            if (q.tog_cnt + 3'h1 == BREAK_TOGGLES && q.win_cnt != 32'h0) begin
                n.active = 1'b0;
                n.tog_cnt = 3'h0;
                n.win_cnt = 32'h0;
            end
        end

        if (session_start_i) begin
            n.cfg = cfg_i;
            n.active = 1'b1;
            n.wr_ptr = 6'h00;
            n.rd_ptr = 6'h00;
            n.count = 6'h00;
            n.txcnt = 3'h0;
            n.tx_valid = 1'b0;
            n.tog_cnt = 3'h0;
            n.win_cnt = 32'h0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.acc <= ACC_IDLE;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign session_active_o = q.active;
    assign rom_data_o = q.rd_data;
    assign rom_data_oe_o = q.rd_oe;
    assign int_p_o = (q.cfg.rcv_int && q.active && q.count != 6'h00) ||
        q.int_cnt != 4'h0;
    assign int_n_o = !int_p_o;
    assign target_rst_o = q.rst_cnt != 4'h0;
    assign rx_lost_o = q.lost;
    assign host_tx_valid_o = q.tx_valid;
    assign host_tx_data_o = q.tx_data;

    ////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    property p_rx_relay;
        pop_w |=> rom_data_o == $past(head_w);
    endproperty
    a_rx_relay: assert property (p_rx_relay)
        else $error("host byte altered on target read");

    property p_rst_pulse;
        q.active && host_rst_req_i |=> target_rst_o [*8];
    endproperty
    a_rst_pulse: assert property (p_rst_pulse)
        else $error("target reset pulse too short");
    property p_burst;
        q.acc == ACC_DONE && q.cfg.burst && rd_s && hit_s &&
            q.rom_s2.addr[1:0] != q.ofs |=> q.acc == ACC_WAIT;
    endproperty
    a_burst: assert property (p_burst)
        else $error("burst access not decoded");
    property p_g1_delay;
        start_w && !q.cfg.gen2 && q.cfg.timing == 2'h1 &&
            !q.rom_s2.addr[1] |=> q.dly == G1_DLY_CYC;
    endproperty
    a_g1_delay: assert property (p_g1_delay)
        else $error("first-gen transmit delay wrong");
    property p_g2_delay;
        start_w && q.cfg.gen2 && q.cfg.timing == 2'h2
            |=> q.dly == G2_DLY2_CYC ##1 q.dly == G2_DLY2_CYC - 4'h1;
    endproperty
    a_g2_delay: assert property (p_g2_delay)
        else $error("second-gen delay wrong");
    property p_no_hit;
        q.acc == ACC_IDLE && !hit_s |=> q.acc == ACC_IDLE;
    endproperty
    a_no_hit: assert property (p_no_hit)
        else $error("access outside channel window taken");
    property p_byte_built;
        act_w && rd_s && !q.rom_s2.addr[1] && q.txcnt == 3'h7 &&
            !q.tx_valid |=> host_tx_valid_o &&
            host_tx_data_o == $past(n.tx_data);
    endproperty
    a_byte_built: assert property (p_byte_built)
        else $error("eighth bit read did not send byte");
    property p_full_drop;
        q.active && host_rx_valid_i && q.count == limit_w
            |=> rx_lost_o && $stable(q.count) || $past(pop_w);
    endproperty
    a_full_drop: assert property (p_full_drop)
        else $error("byte into full buffer not dropped");

    property p_fast_depth;
        q.cfg.fast |-> q.count <= RX_FAST_DEPTH;
    endproperty
    a_fast_depth: assert property (p_fast_depth)
        else $error("fast mode buffered more than one byte");

    property p_rx_int;
        q.active && q.cfg.rcv_int && q.count != 6'h00 |-> int_p_o && !int_n_o;
    endproperty
    a_rx_int: assert property (p_rx_int)
        else $error("receive interrupt missing");

    property p_cfg_hold;
        q.active && !session_start_i |=> $stable(q.cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("settings changed within session");

    property p_break;
        q.active && tog_w && q.tog_cnt == 3'h3 && q.win_cnt != 32'h0 &&
            !session_start_i |=> ##[0:2] !session_active_o;
    endproperty
    a_break: assert property (p_break)
        else $error("session not ended by toggles");

    c_tx_byte: cover property (q.tx_valid && host_tx_ready_i);
    c_rx_pop: cover property (pop_w);
    c_full: cover property (q.count == RX_DEPTH);
    c_burst: cover property (q.acc == ACC_DONE ##1 q.acc == ACC_WAIT);
endmodule
`default_nettype wire

// ### logic/rvc_pkg.sv
/*
 * Shared constants and types for the ROM-mapped virtual serial channel:
 * register offsets, status bits, access delays and pulse lengths.
 * Assumes a 250 MHz system clock and an 8 bit ROM bus.
 */
`default_nettype none
package rvc_pkg;
    localparam int ADDR_W = 19;
    // channel register offsets within the four-byte window
    localparam logic [1:0] OFS_BIT0 = 2'h0;
    localparam logic [1:0] OFS_BIT1 = 2'h1;
    localparam logic [1:0] OFS_RXDATA = 2'h2;
    localparam logic [1:0] OFS_STATUS = 2'h3;
    localparam int STAT_HBA_BIT = 0;
    localparam int STAT_TXBUSY_BIT = 1;
    // receive buffer
    localparam logic [5:0] RX_DEPTH = 6'h28;
    localparam logic [5:0] RX_LAST = 6'h27;
    localparam logic [5:0] RX_FAST_DEPTH = 6'h01;
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLK_KHZ = 250000;
    localparam int G1_DELAY_NS = 50;
    localparam int G2_DELAY0_NS = 20;
    localparam int G2_DELAY1_NS = 40;
    localparam int G2_DELAY2_NS = 60;
    localparam logic [3:0] G1_DLY_CYC =
        4'((G1_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] G2_DLY0_CYC =
        4'((G2_DELAY0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] G2_DLY1_CYC =
        4'((G2_DELAY1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] G2_DLY2_CYC =
        4'((G2_DELAY2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int PULSE_NS = 32;
    localparam logic [3:0] PULSE_CYC = 4'(PULSE_NS / CLK_PERIOD_NS);
    localparam int SENSE_PERIOD_MS = 5000;
    localparam logic [2:0] BREAK_TOGGLES = 3'h4;

    typedef enum logic [2:0] {
        ACC_IDLE = 3'b001,
        ACC_WAIT = 3'b010,
        ACC_DONE = 3'b100
    } rvc_acc_t;

    typedef struct packed {
        logic gen2;
        logic [1:0] timing;
        logic fast;
        logic direct_wr;
        logic rcv_int;
        logic burst;
        logic [ADDR_W-1:0] base;
    } rvc_cfg_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } rvc_rom_t;

    typedef struct packed {
        rvc_acc_t acc;
        logic [3:0] dly;
        logic [1:0] ofs;
        rvc_rom_t rom_s1;
        rvc_rom_t rom_s2;
        logic ctl_s1;
        logic ctl_s2;
        logic ctl_prev;
        rvc_cfg_t cfg;
        logic active;
        logic [7:0] txsh;
        logic [2:0] txcnt;
        logic tx_valid;
        logic [7:0] tx_data;
        logic [39:0][7:0] mem;
        logic [5:0] wr_ptr;
        logic [5:0] rd_ptr;
        logic [5:0] count;
        logic [7:0] rd_data;
        logic rd_oe;
        logic lost;
        logic [2:0] tog_cnt;
        logic [31:0] win_cnt;
        logic [3:0] int_cnt;
        logic [3:0] rst_cnt;
    } rvc_state_t;
endpackage
`default_nettype wire

// ### tb/rvc_target_model.sv
/*
 * Target monitor model: makes ROM read and write accesses on the
 * channel's pins, one access per strobe (two in the burst task brd), released between tasks.
 * Assumes the channel answers reads by raising rom_data_oe_i.
 */
`default_nettype none
module rvc_target_model
    import rvc_pkg::*;
(
    // clock
    input wire logic mclk_i,
    // channel answer
    input wire logic [7:0] rom_data_i,
    input wire logic rom_data_oe_i,
    // rom pins toward the channel
    output var rvc_pkg::rvc_rom_t rom_o
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////
    initial begin
        rom_o = {3'h7, 19'h0, 8'hFF};
    end
    // strobes held until data is driven, lat counts cycles
    task automatic rd(input logic [18:0] a, output logic [7:0] d,
                      output int lat);
        lat = 0;
        @(negedge mclk_i);
        rom_o.addr = a;
        rom_o.ce_n = 1'b0;
        rom_o.oe_n = 1'b0;
        while (rom_data_oe_i !== 1'b1 && lat < 60) begin
            @(negedge mclk_i);
            lat++;
        end
        d = rom_data_i;
        rom_o.ce_n = 1'b1;
        rom_o.oe_n = 1'b1;
        rom_o.addr = ~a;
        repeat (6) @(negedge mclk_i);
    endtask
    // offset changed under held strobes, burst style
    task automatic brd(input logic [18:0] a0, input logic [18:0] a1,
                       output logic [7:0] d0, output logic [7:0] d1);
        int lat;
        lat = 0;
        @(negedge mclk_i);
        rom_o.addr = a0;
        rom_o.ce_n = 1'b0;
        rom_o.oe_n = 1'b0;
        while (rom_data_oe_i !== 1'b1 && lat < 60) begin
            @(negedge mclk_i);
            lat++;
        end
        d0 = rom_data_i;
        rom_o.addr = a1;
        repeat (6) @(negedge mclk_i);
        d1 = rom_data_i;
        rom_o.ce_n = 1'b1;
        rom_o.oe_n = 1'b1;
        rom_o.addr = ~a1;
        repeat (6) @(negedge mclk_i);
    endtask
    // write held past the longest delay
    task automatic wr(input logic [18:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        rom_o.addr = a;
        rom_o.wdata = d;
        rom_o.ce_n = 1'b0;
        rom_o.we_n = 1'b0;
        repeat (24) @(negedge mclk_i);
        rom_o.ce_n = 1'b1;
        rom_o.we_n = 1'b1;
        rom_o.wdata = ~d;
        rom_o.addr = ~a;
        repeat (6) @(negedge mclk_i);
    endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
/*
 * Self-checking bench for the virtual serial channel: host link,
 * session control and target accesses through the monitor model.
 * Assumes a 250 MHz clock and a short break sensing window.
 */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rvc_pkg::*;
    localparam logic [18:0] BASE = 19'h00100;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic session_start_i = 1'b0;
    rvc_cfg_t cfg_i = '0;
    rvc_rom_t rom_i;
    logic session_active_o, rom_data_oe_o, int_p_o, int_n_o;
    logic [7:0] rom_data_o, host_tx_data_o;
    logic target_rst_o, rx_lost_o, host_tx_valid_o;
    logic host_rx_valid_i = 1'b0;
    logic [7:0] host_rx_data_i = 8'h00;
    logic host_tx_ready_i = 1'b1;
    logic host_int_req_i = 1'b0;
    logic host_rst_req_i = 1'b0;
    logic host_ctl_line_i = 1'b0;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    int n_lost = 0;
    logic [7:0] txq[$];
    ////////////////////////////////////////////////////////////////////
    rvc_channel #(.SENSE_CYCLES(100)) dut (.mclk_i, .rst_n_i,
        .session_start_i, .cfg_i, .session_active_o, .rom_i, .rom_data_o,
        .rom_data_oe_o, .int_p_o, .int_n_o, .target_rst_o,
        .host_rx_valid_i, .host_rx_data_i, .rx_lost_o, .host_tx_valid_o,
        .host_tx_data_o, .host_tx_ready_i, .host_int_req_i,
        .host_rst_req_i, .host_ctl_line_i);
    rvc_target_model tm (.mclk_i, .rom_data_i(rom_data_o),
        .rom_data_oe_i(rom_data_oe_o), .rom_o(rom_i));
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cyc++;
        if (host_tx_valid_o === 1'b1 && host_tx_ready_i === 1'b1)
            txq.push_back(host_tx_data_o);
        if (rx_lost_o === 1'b1) n_lost++;
        if (cyc == 40000) begin
            n_errors++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %0h not %0h", $time, m, got, exp);
        end
    endtask
    // c = {gen2, timing, fast, direct_wr, rcv_int, burst}
    task automatic open_s(input logic [6:0] c);
        @(negedge mclk_i);
        cfg_i = {c, BASE};
        session_start_i = 1'b1;
        @(negedge mclk_i);
        session_start_i = 1'b0;
        txq.delete();
        chk(session_active_o, 1'b1, "session open");
    endtask
    task automatic hsend(input logic [7:0] b);
        @(negedge mclk_i);
        host_rx_valid_i = 1'b1;
        host_rx_data_i = b;
        @(negedge mclk_i);
        host_rx_valid_i = 1'b0;
    endtask
    task automatic trd(input logic [1:0] o, output logic [7:0] d);
        int l;
        tm.rd(BASE + 19'(o), d, l);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_tx;
        logic [7:0] d;
        int l;
        open_s(7'h00);
        tm.rd(BASE + 19'h4, d, l);
        for (int i = 0; i < 8; i++) trd({1'b0, 1'(8'hA5 >> i)}, d);
        repeat (4) @(negedge mclk_i);
        chk(txq.size(), 1, "tx count");
        chk(txq[0], 8'hA5, "tx byte");
        open_s(7'h04);
        tm.wr(BASE, 8'h3C);
        chk(txq.size(), 0, "gen1 direct write");
        open_s(7'h44);
        host_tx_ready_i = 1'b0;
        tm.wr(BASE, 8'h3C);
        tm.wr(BASE, 8'h5A);
        chk({host_tx_valid_o, host_tx_data_o}, 9'h13C, "busy hold");
        host_tx_ready_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        chk(txq.size(), 1, "direct count");
        chk(txq[0], 8'h3C, "direct byte");
        $display("t_tx done");
    endtask
    task automatic t_rx;
        logic [7:0] d;
        int l0;
        open_s(7'h02);
        chk(int_p_o, 1'b0, "int idle");
        l0 = n_lost;
        for (int i = 0; i < 41; i++) hsend(8'h40 + 8'(i));
        repeat (2) @(negedge mclk_i);
        chk(n_lost - l0, 1, "overflow loss");
        chk({int_p_o, int_n_o}, 2'b10, "int raised");
        trd(OFS_STATUS, d);
        chk(d[STAT_HBA_BIT], 1'b1, "byte flag");
        for (int i = 0; i < 40; i++) begin
            trd(OFS_RXDATA, d);
            chk(d, 8'h40 + 8'(i), "rx byte");
        end
        chk({int_p_o, int_n_o}, 2'b01, "int cleared");
        trd(OFS_STATUS, d);
        chk(d[STAT_HBA_BIT], 1'b0, "flag cleared");
        $display("t_rx done");
    endtask
    task automatic t_fast;
        logic [7:0] d;
        int l0;
        open_s(7'h08);
        cfg_i.fast = 1'b0;
        l0 = n_lost;
        hsend(8'h11);
        hsend(8'h22);
        repeat (2) @(negedge mclk_i);
        chk(n_lost - l0, 1, "fast loss");
        trd(OFS_RXDATA, d);
        chk(d, 8'h11, "fast byte");
        $display("t_fast done");
    endtask
    task automatic t_delay;
        logic [2:0] m[7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
        int e[7] = '{0, 0, int'(G1_DLY_CYC), int'(G2_DLY0_CYC),
                     int'(G2_DLY1_CYC), int'(G2_DLY2_CYC), 0};
        logic [7:0] d;
        int l, r;
        r = 0;
        // settings below stay under the memory access time
        for (int i = 0; i < 7; i++) begin
            open_s({m[i], 4'h0});
            tm.rd(BASE + 19'h3, d, l);
            if (i == 0) r = l;
            chk(l - r, e[i], "delay");
        end
        open_s(7'h10);
        tm.rd(BASE, d, l);
        chk(l - r, int'(G1_DLY_CYC), "tx delay");
        $display("t_delay done");
    endtask
    task automatic t_burst;
        logic [7:0] d0, d1;
        open_s(7'h01);
        hsend(8'h5A);
        tm.brd(BASE + 19'(OFS_STATUS), BASE + 19'(OFS_RXDATA), d0, d1);
        chk(d0[STAT_HBA_BIT], 1'b1, "burst status");
        chk(d1, 8'h5A, "burst byte");
        $display("t_burst done");
    endtask
    task automatic t_req;
        int ni, nr;
        ni = 0;
        nr = 0;
        open_s(7'h00);
        @(negedge mclk_i);
        host_int_req_i = 1'b1;
        host_rst_req_i = 1'b1;
        @(negedge mclk_i);
        host_int_req_i = 1'b0;
        host_rst_req_i = 1'b0;
        repeat (30) begin
            ni += int'(int_p_o === 1'b1);
            nr += int'(target_rst_o === 1'b1);
            @(negedge mclk_i);
        end
        chk(ni, int'(PULSE_CYC), "int pulse");
        chk(nr, int'(PULSE_CYC), "reset pulse");
        $display("t_req done");
    endtask
    task automatic t_break;
        open_s(7'h00);
        for (int i = 0; i < 4; i++) begin
            if (i == 3) chk(session_active_o, 1'b1, "three toggles");
            host_ctl_line_i = ~host_ctl_line_i;
            repeat (4) @(negedge mclk_i);
        end
        repeat (4) @(negedge mclk_i);
        chk(session_active_o, 1'b0, "session broken");
        $display("t_break done");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge mclk_i);
        rst_n_i = 1'b1;
        @(negedge mclk_i);
        chk({session_active_o, int_p_o, int_n_o, host_tx_valid_o}, 4'h2,
            "reset outputs");
        t_tx();
        t_rx();
        t_fast();
        t_delay();
        t_burst();
        t_req();
        t_break();
        complete_run();
    end
endmodule
`default_nettype wire
